// *** sync_verify_phase_mode_consts.svh ***
// timing, display codes and limits for the start-up and mode sequencer
`ifndef SYNC_VERIFY_PHASE_MODE_CONSTS_SVH
`define SYNC_VERIFY_PHASE_MODE_CONSTS_SVH
`define CLK_PERIOD_NS 20
`define NS_PER_MS 1000000
`define RESET_HOLD_LIMIT_MS 3000
`define EVAL_CYCLE_MS 8
`define SLOW_FLASH_HALF_MS 500
`define FAST_FLASH_HALF_MS 125
`define CODE_SYNC 4'h1
`define CODE_CONFIG 4'h2
`define CODE_BUS 4'h3
`define CODE_RUN 4'h4
`define CODE_STOP 4'h5
`define CODE_ALARM 4'ha
`define CODE_CROSS 4'he
`define CODE_FATAL 4'hf
`define FLASH_CNT_W 25
`endif

// *** sync_verify_phase_mode_pkg.sv ***
// types shared by the start-up and mode sequencer
package sync_verify_phase_mode_pkg;
	typedef enum logic [8:0] {
		sync_verify_phase = 9'h001,
		config_transfer_phase = 9'h002,
		bus_init_phase = 9'h004,
		run_mode = 9'h008,
		stop_mode = 9'h010,
		alarm_state = 9'h020,
		cross_alarm_state = 9'h040,
		fatal_state = 9'h080,
		config_repeat_phase = 9'h100
	} mode_e;
	typedef enum logic [1:0] {
		bus_unused = 2'h0,
		bus_unconnected = 2'h1,
		bus_pending = 2'h2,
		bus_connected = 2'h3
	} bus_link_e;
	// phase handshake with the processing logic
	typedef struct packed {
		logic start;
		logic done;
		logic fail;
	} phase_hs_s;
	// alarm sources seen in operation
	typedef struct packed {
		logic alarm;
		logic cross_check_alarm_e;
		logic cross_check_alarm_i;
		logic cross_check_alarm_a;
		logic fatal;
	} fault_s;
endpackage : sync_verify_phase_mode_pkg

// *** sync_verify_phase_mode_sequencer.sv ***
// start-up phase and operating mode sequencer with status display and bus indicator
`include "sync_verify_phase_mode_consts.svh"
module sync_verify_phase_mode_sequencer #(
	parameter int OUT_W = 8,
	parameter int EMPTY_W = 4,
	parameter int RESET_LIMIT_CYC = `RESET_HOLD_LIMIT_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
	parameter int SLOW_HALF_CYC = `SLOW_FLASH_HALF_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
	parameter int FAST_HALF_CYC = `FAST_FLASH_HALF_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
) (
	input wire logic sys_clk_i, // 50 MHz
	input wire logic reset_i, // sync, high
	input wire logic bus_fitted_i, // fieldbus interface present
	input wire sync_verify_phase_mode_pkg::phase_hs_s sync_hs_i, // done/fail of sync and verify
	input wire sync_verify_phase_mode_pkg::phase_hs_s xfer_hs_i, // done/fail of each transfer
	input wire sync_verify_phase_mode_pkg::phase_hs_s range_hs_i, // done/fail of range check
	input wire sync_verify_phase_mode_pkg::phase_hs_s bus_hs_i, // done/fail of bus init
	input wire sync_verify_phase_mode_pkg::fault_s fault_i, // fault events
	input wire logic stop_req_i, // enter stop mode
	input wire logic run_req_i, // leave stop mode
	input wire logic [OUT_W-1:0] eval_result_i, // evaluation logic result
	input wire logic load_valid_i, // external parameter word valid
	input wire logic reset_in_i, // digital reset input
	input wire logic ack_button_i, // front acknowledge button
	input wire logic eval_tick_i, // one pulse per evaluation cycle
	input wire logic reading_valid_i, // reading strobe
	input wire logic reading_marker_i, // reading holds a code marker
	input wire logic [EMPTY_W-1:0] empty_allowed_i, // permitted empty readings
	input wire sync_verify_phase_mode_pkg::bus_link_e bus_link_i, // safety bus link state
	output logic [3:0] display_code_o, // seven-segment code
	output logic [OUT_W-1:0] outputs_o, // safety outputs
	output logic sync_start_o, // pulse: start sync and verify
	output logic xfer_start_o, // pulse: start transfer
	output logic range_start_o, // pulse: start range check
	output logic bus_start_o, // pulse: start bus init
	output logic load_accept_o, // load word taken
	output logic internal_reset_o, // pulse: internal reset
	output logic marker_fault_o, // empty readings exceeded
	output logic safety_bus_indicator_o // indicator LED
);
	sync_verify_phase_mode_pkg::mode_e mode, next_mode;
	logic step, next_step;
	logic started, next_started;
	logic [3:0] display_code, next_display_code;
	logic [OUT_W-1:0] outputs, next_outputs;
	logic sync_start, next_sync_start;
	logic xfer_start, next_xfer_start;
	logic range_start, next_range_start;
	logic bus_start, next_bus_start;
	logic load_accept, next_load_accept;
	logic internal_reset, next_internal_reset;
	logic reset_in_q, next_reset_in_q;
	logic [31:0] hold_cnt, next_hold_cnt;
	logic [EMPTY_W-1:0] empty_cnt, next_empty_cnt;
	logic marker_fault, next_marker_fault;
	logic [`FLASH_CNT_W-1:0] flash_cnt, next_flash_cnt;
	logic flash, next_flash;
	logic indicator, next_indicator;
	logic clear_req;
	logic run_reset;
	logic any_cross;

	assign any_cross = fault_i.cross_check_alarm_e | fault_i.cross_check_alarm_i | fault_i.cross_check_alarm_a;
	// a reset input edge and the button both count as acknowledge in the alarm and cross alarm states
	assign clear_req = (reset_in_i & ~reset_in_q) | ack_button_i;
	// falling edge of reset input after a short press only
	assign run_reset = ~reset_in_i & reset_in_q & (hold_cnt < 32'(RESET_LIMIT_CYC));

	always_comb
	begin
		next_mode = mode;
		next_step = step;
		next_started = 1'b0;
		next_outputs = '0;
		next_sync_start = 1'b0;
		next_xfer_start = 1'b0;
		next_range_start = 1'b0;
		next_bus_start = 1'b0;
		next_load_accept = 1'b0;
		next_internal_reset = 1'b0;
		unique case (mode)
			sync_verify_phase_mode_pkg::sync_verify_phase:
			begin
				next_sync_start = ~started & ~step;
				next_step = 1'b1;
				next_started = step;
				if (sync_hs_i.fail)
					next_mode = sync_verify_phase_mode_pkg::fatal_state;
				else if (sync_hs_i.done & step)
				begin
					next_mode = sync_verify_phase_mode_pkg::config_transfer_phase;
					next_step = 1'b0;
				end
			end
			sync_verify_phase_mode_pkg::config_transfer_phase:
			begin
				next_xfer_start = ~step;
				next_step = 1'b1;
				if (xfer_hs_i.fail)
					next_mode = sync_verify_phase_mode_pkg::fatal_state;
				else if (xfer_hs_i.done & step)
				begin
					next_mode = sync_verify_phase_mode_pkg::config_repeat_phase;
					next_step = 1'b0;
				end
			end
			sync_verify_phase_mode_pkg::config_repeat_phase:
			begin
				// repeated transfer, then the range check, still shown as phase 2
				next_xfer_start = ~step & ~started;
				next_started = 1'b1;
				if (xfer_hs_i.fail | range_hs_i.fail)
					next_mode = sync_verify_phase_mode_pkg::fatal_state;
				else if (xfer_hs_i.done & started & ~step)
				begin
					next_step = 1'b1;
					next_range_start = 1'b1;
				end
				else if (range_hs_i.done & step)
				begin
					next_mode = sync_verify_phase_mode_pkg::bus_init_phase;
					next_step = 1'b0;
					next_started = 1'b0;
				end
			end
			sync_verify_phase_mode_pkg::bus_init_phase:
			begin
				next_bus_start = bus_fitted_i & ~step;
				next_step = 1'b1;
				if (!bus_fitted_i)
					next_mode = sync_verify_phase_mode_pkg::run_mode;
				else if (bus_hs_i.fail)
					next_mode = sync_verify_phase_mode_pkg::fatal_state;
				else if (bus_hs_i.done & step)
					next_mode = sync_verify_phase_mode_pkg::run_mode;
			end
			sync_verify_phase_mode_pkg::run_mode:
			begin
				next_outputs = eval_result_i;
				next_internal_reset = run_reset;
				if (fault_i.fatal)
					next_mode = sync_verify_phase_mode_pkg::fatal_state;
				else if (any_cross)
					next_mode = sync_verify_phase_mode_pkg::cross_alarm_state;
				else if (fault_i.alarm | marker_fault)
					next_mode = sync_verify_phase_mode_pkg::alarm_state;
				else if (stop_req_i)
					next_mode = sync_verify_phase_mode_pkg::stop_mode;
			end
			sync_verify_phase_mode_pkg::stop_mode:
			begin
				next_load_accept = load_valid_i;
				if (fault_i.fatal)
					next_mode = sync_verify_phase_mode_pkg::fatal_state;
				else if (run_req_i)
					next_mode = sync_verify_phase_mode_pkg::run_mode;
			end
			sync_verify_phase_mode_pkg::alarm_state:
			begin
				if (fault_i.fatal)
					next_mode = sync_verify_phase_mode_pkg::fatal_state;
				else if (clear_req)
				begin
					next_mode = sync_verify_phase_mode_pkg::run_mode;
					next_internal_reset = 1'b1;
				end
			end
			sync_verify_phase_mode_pkg::cross_alarm_state:
			begin
				if (fault_i.fatal)
					next_mode = sync_verify_phase_mode_pkg::fatal_state;
				else if (clear_req)
				begin
					next_mode = sync_verify_phase_mode_pkg::run_mode;
					next_internal_reset = 1'b1;
				end
			end
			sync_verify_phase_mode_pkg::fatal_state:
				next_mode = sync_verify_phase_mode_pkg::fatal_state;
		endcase
	end

	always_comb
	begin
		next_display_code = display_code;
		unique case (next_mode)
			sync_verify_phase_mode_pkg::sync_verify_phase: next_display_code = `CODE_SYNC;
			sync_verify_phase_mode_pkg::config_transfer_phase: next_display_code = `CODE_CONFIG;
			sync_verify_phase_mode_pkg::config_repeat_phase: next_display_code = `CODE_CONFIG;
			sync_verify_phase_mode_pkg::bus_init_phase: next_display_code = `CODE_BUS;
			sync_verify_phase_mode_pkg::run_mode: next_display_code = `CODE_RUN;
			sync_verify_phase_mode_pkg::stop_mode: next_display_code = `CODE_STOP;
			sync_verify_phase_mode_pkg::alarm_state: next_display_code = `CODE_ALARM;
			sync_verify_phase_mode_pkg::cross_alarm_state: next_display_code = `CODE_CROSS;
			sync_verify_phase_mode_pkg::fatal_state: next_display_code = `CODE_FATAL;
		endcase
	end

	// reset input hold timer; saturates so a long press never wraps back under the limit
	always_comb
	begin
		next_reset_in_q = reset_in_i;
		next_hold_cnt = hold_cnt;
		if (reset_in_i & ~reset_in_q)
			next_hold_cnt = '0;
		else if (reset_in_i && hold_cnt < 32'(RESET_LIMIT_CYC))
			next_hold_cnt = hold_cnt + 32'h1;
	end

	// empty readings only fault once the permitted run is exceeded
	always_comb
	begin
		next_empty_cnt = empty_cnt;
		next_marker_fault = marker_fault;
		if (mode != sync_verify_phase_mode_pkg::run_mode)
		begin
			next_empty_cnt = '0;
			next_marker_fault = 1'b0;
		end
		else if (reading_valid_i & eval_tick_i)
		begin
			// one reading per evaluation cycle, so delay is count times cycle period
			if (reading_marker_i)
				next_empty_cnt = '0;
			else if (empty_cnt >= empty_allowed_i)
				next_marker_fault = 1'b1;
			else
				next_empty_cnt = empty_cnt + EMPTY_W'(1);
		end
	end

	always_comb
	begin
		next_flash_cnt = flash_cnt + `FLASH_CNT_W'(1);
		next_flash = flash;
		if ((bus_link_i == sync_verify_phase_mode_pkg::bus_unconnected && flash_cnt >= `FLASH_CNT_W'(SLOW_HALF_CYC - 1))
			|| (bus_link_i == sync_verify_phase_mode_pkg::bus_pending && flash_cnt >= `FLASH_CNT_W'(FAST_HALF_CYC - 1)))
		begin
			next_flash_cnt = '0;
			next_flash = ~flash;
		end
		unique case (bus_link_i)
			sync_verify_phase_mode_pkg::bus_unused: next_indicator = 1'b0;
			sync_verify_phase_mode_pkg::bus_unconnected: next_indicator = flash;
			sync_verify_phase_mode_pkg::bus_pending: next_indicator = flash;
			sync_verify_phase_mode_pkg::bus_connected: next_indicator = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			mode <= sync_verify_phase_mode_pkg::sync_verify_phase;
			step <= 1'b0;
			started <= 1'b0;
			display_code <= `CODE_SYNC;
			outputs <= '0;
			sync_start <= 1'b0;
			xfer_start <= 1'b0;
			range_start <= 1'b0;
			bus_start <= 1'b0;
			load_accept <= 1'b0;
			internal_reset <= 1'b0;
			reset_in_q <= 1'b0;
			hold_cnt <= '0;
			empty_cnt <= '0;
			marker_fault <= 1'b0;
			flash_cnt <= '0;
			flash <= 1'b0;
			indicator <= 1'b0;
		end
		else
		begin
			mode <= next_mode;
			step <= next_step;
			started <= next_started;
			display_code <= next_display_code;
			outputs <= next_outputs;
			sync_start <= next_sync_start;
			xfer_start <= next_xfer_start;
			range_start <= next_range_start;
			bus_start <= next_bus_start;
			load_accept <= next_load_accept;
			internal_reset <= next_internal_reset;
			reset_in_q <= next_reset_in_q;
			hold_cnt <= next_hold_cnt;
			empty_cnt <= next_empty_cnt;
			marker_fault <= next_marker_fault;
			flash_cnt <= next_flash_cnt;
			flash <= next_flash;
			indicator <= next_indicator;
		end
	end

	assign display_code_o = display_code;
	assign outputs_o = outputs;
	assign sync_start_o = sync_start;
	assign xfer_start_o = xfer_start;
	assign range_start_o = range_start;
	assign bus_start_o = bus_start;
	assign load_accept_o = load_accept;
	assign internal_reset_o = internal_reset;
	assign marker_fault_o = marker_fault;
	assign safety_bus_indicator_o = indicator;
endmodule : sync_verify_phase_mode_sequencer

// *** sync_verify_phase_mode_sva.sv ***
// port assertions for the start-up and mode sequencer
module sync_verify_phase_mode_sva #(
	parameter int OUT_W = 8
) (
	input wire logic sys_clk_i, // clock
	input wire logic reset_i, // reset
	input wire logic [OUT_W-1:0] eval_result_i, // result
	input wire logic load_valid_i, // load
	input wire logic reset_in_i, // reset input
	input wire logic ack_button_i, // button
	input wire logic [3:0] display_code_o, // display
	input wire logic [OUT_W-1:0] outputs_o, // outputs
	input wire logic sync_start_o, // start
	input wire logic load_accept_o, // taken
	input wire logic internal_reset_o // pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	logic [3:0] d;
	assign d = display_code_o;
	sequence s_clear;
		$rose(ack_button_i) || $rose(reset_in_i);
	endsequence
	sequence s_back;
		d == 4'h4 && internal_reset_o;
	endsequence
	property p_order;
		$changed(d) && $past(d) inside {4'h1, 4'h2, 4'h3} |->
			d == $past(d) + 4'h1 || d == 4'hf || ($past(d) == 4'h2 && d == 4'h4);
	endproperty
	a_order: assert property (p_order) else $error("phase order");
	property p_start;
		$fell(reset_i) |-> ##[0:1] sync_start_o;
	endproperty
	a_start: assert property (p_start) else $error("no sync start");
	property p_fatal;
		d == 4'hf |=> d == 4'hf;
	endproperty
	a_fatal: assert property (p_fatal) else $error("left fatal");
	property p_run;
		$past(d) == 4'h4 && d == 4'h4 |-> outputs_o == $past(eval_result_i);
	endproperty
	a_run: assert property (p_run) else $error("outputs in run");
	property p_idle;
		$past(d) != 4'h4 && d != 4'h4 |-> outputs_o == '0;
	endproperty
	a_idle: assert property (p_idle) else $error("outputs outside run");
	property p_load;
		$past(d) == 4'h5 && d == 4'h5 |-> load_accept_o == $past(load_valid_i);
	endproperty
	a_load: assert property (p_load) else $error("load accept");
	property p_alarm;
		d == 4'ha ##0 s_clear |=> s_back;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm clear");
	property p_cross;
		d == 4'he ##0 s_clear |=> s_back;
	endproperty
	a_cross: assert property (p_cross) else $error("cross clear");
endmodule : sync_verify_phase_mode_sva

// *** phase_worker_model.sv ***
// model of the phase workers answering start pulses
module phase_worker_model (
	input wire logic sys_clk_i, // clock
	input wire logic [3:0] start_i, // sync, xfer, range, bus
	input wire logic [3:0] fail_mask_i, // phases that fail
	output logic [3:0] done_o = 4'h0, // done pulses
	output logic [3:0] fail_o = 4'h0 // fail pulses
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pend = 4'h0;
	logic [1:0] cnt = 2'h0;
	// answer a few cycles late so the sequencer must wait
	always @(posedge sys_clk_i)
	begin
		done_o <= 4'h0;
		fail_o <= 4'h0;
		if (start_i != 4'h0)
		begin
			pend <= start_i;
			cnt <= 2'h3;
		end
		else if (pend != 4'h0 && cnt != 2'h0)
			cnt <= cnt - 2'h1;
		else if (pend != 4'h0)
		begin
			done_o <= pend & ~fail_mask_i;
			fail_o <= pend & fail_mask_i;
			pend <= 4'h0;
		end
	end
endmodule : phase_worker_model

// *** sync_verify_phase_mode_sequencer_test.sv ***
// self-checking bench for the start-up and mode sequencer
module sync_verify_phase_mode_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		sync_verify_phase_mode_pkg::fault_s f;
		logic [3:0] code;
		logic btn;
	} row_s;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic fit = 1'b1, stop_r = 1'b0, run_r = 1'b0, load_v = 1'b0, rst_in = 1'b0, btn = 1'b0;
	logic tick = 1'b0, rd_v = 1'b0, mark = 1'b0, l_acc, irst, mflt, led, led_q;
	logic [3:0] allow = 4'h2, mask = 4'h0, st, dn, fl, disp;
	logic [7:0] eval = 8'h00, outs;
	sync_verify_phase_mode_pkg::fault_s fault = '0;
	sync_verify_phase_mode_pkg::bus_link_e link = sync_verify_phase_mode_pkg::bus_unused;
	int errors = 0, num_checks = 0, n_xfer, n_bus, n_irst, tog;
	int togs [4];
	row_s rows [5];
	sync_verify_phase_mode_sequencer #(.RESET_LIMIT_CYC(20), .SLOW_HALF_CYC(8), .FAST_HALF_CYC(2)) sync_verify_phase_mode_sequencer_inst (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_fitted_i(fit),
		.sync_hs_i({1'b0, dn[0], fl[0]}), .xfer_hs_i({1'b0, dn[1], fl[1]}),
		.range_hs_i({1'b0, dn[2], fl[2]}), .bus_hs_i({1'b0, dn[3], fl[3]}),
		.fault_i(fault), .stop_req_i(stop_r), .run_req_i(run_r), .eval_result_i(eval),
		.load_valid_i(load_v), .reset_in_i(rst_in), .ack_button_i(btn), .eval_tick_i(tick),
		.reading_valid_i(rd_v), .reading_marker_i(mark), .empty_allowed_i(allow), .bus_link_i(link),
		.display_code_o(disp), .outputs_o(outs), .sync_start_o(st[0]), .xfer_start_o(st[1]),
		.range_start_o(st[2]), .bus_start_o(st[3]), .load_accept_o(l_acc),
		.internal_reset_o(irst), .marker_fault_o(mflt), .safety_bus_indicator_o(led));
	phase_worker_model phase_worker_model_inst (.sys_clk_i(sys_clk_i), .start_i(st),
		.fail_mask_i(mask), .done_o(dn), .fail_o(fl));
	initial forever #10 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
	begin
		eval <= #2 eval + 8'h1;
		n_xfer += int'(st[1]);
		n_bus += int'(st[3]);
		n_irst += int'(irst);
		tog += int'(led !== led_q);
		led_q <= led;
	end
	task automatic step(input int n = 1);
		repeat (n) @(posedge sys_clk_i);
		#2;
	endtask : step
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		num_checks++;
		if (got !== exp)
			$display("ERROR %0t got %h want %h", $time, got, exp);
		errors += int'(got !== exp);
	endtask : chk
	task automatic wait_code(input logic [3:0] c);
		for (int i = 0; i < 60 && disp !== c; i++) step();
		chk(disp, c);
	endtask : wait_code
	task automatic boot();
		reset_i = 1'b1;
		step(4);
		reset_i = 1'b0;
		n_xfer = 0;
		n_bus = 0;
	endtask : boot
	task automatic results();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	initial
	begin
		#200000;
		errors++;
		results();
	end
	initial
	begin
		rows = '{'{5'h10, 4'ha, 1'b1}, '{5'h08, 4'he, 1'b0}, '{5'h04, 4'he, 1'b1},
			'{5'h02, 4'he, 1'b0}, '{5'h01, 4'hf, 1'b1}};
		foreach (rows[i])
		begin
			boot();
			wait_code(4'h4);
			chk(4'(n_xfer), 4'h2);
			chk(4'(n_bus), 4'h1);
			fault = rows[i].f;
			step();
			fault = '0;
			step();
			chk(disp, rows[i].code);
			btn = rows[i].btn;
			rst_in = ~rows[i].btn;
			step();
			chk(disp, rows[i].code == 4'hf ? 4'hf : 4'h4);
			chk({3'h0, irst}, {3'h0, rows[i].code != 4'hf});
			btn = 1'b0;
			rst_in = 1'b0;
			step(3);
			$display("fault row %0d done", i);
		end
		for (int j = 0; j < 4; j++)
		begin
			mask = 4'h1 << j;
			boot();
			wait_code(4'hf);
			btn = 1'b1;
			step(2);
			chk(disp, 4'hf);
			btn = 1'b0;
		end
		mask = 4'h0;
		fit = 1'b0;
		boot();
		wait_code(4'h4);
		chk(4'(n_bus), 4'h0);
		$display("start-up tests done");
		stop_r = 1'b1;
		step();
		stop_r = 1'b0;
		wait_code(4'h5);
		load_v = 1'b1;
		step(2);
		chk({3'h0, l_acc}, 4'h1);
		load_v = 1'b0;
		run_r = 1'b1;
		step();
		run_r = 1'b0;
		wait_code(4'h4);
		$display("stop test done");
		// short press resets, a press past the limit must not
		n_irst = 0;
		rst_in = 1'b1;
		step(5);
		rst_in = 1'b0;
		step(4);
		chk(4'(n_irst), 4'h1);
		rst_in = 1'b1;
		step(30);
		rst_in = 1'b0;
		step(4);
		chk(4'(n_irst), 4'h1);
		$display("reset input test done");
		{rd_v, tick} = 2'h3;
		step(2);
		mark = 1'b1;
		step();
		mark = 1'b0;
		step(2);
		{rd_v, tick} = 2'h0;
		step(2);
		chk(disp, 4'h4);
		chk({3'h0, mflt}, 4'h0);
		{rd_v, tick} = 2'h3;
		step();
		chk({3'h0, mflt}, 4'h1);
		{rd_v, tick} = 2'h0;
		wait_code(4'ha);
		$display("empty reading test done");
		for (int k = 0; k < 4; k++)
		begin
			link = sync_verify_phase_mode_pkg::bus_link_e'(k);
			step(4);
			tog = 0;
			step(32);
			togs[k] = tog;
		end
		chk({3'h0, togs[0] + togs[3] == 0 && togs[1] inside {[3:5]} && togs[2] inside {[15:17]}}, 4'h1);
		$display("indicator test done");
		results();
	end
endmodule : sync_verify_phase_mode_sequencer_test
bind sync_verify_phase_mode_sequencer sync_verify_phase_mode_sva #(.OUT_W(OUT_W)) sync_verify_phase_mode_sva_inst (.sys_clk_i(sys_clk_i),
	.reset_i(reset_i), .eval_result_i(eval_result_i), .load_valid_i(load_valid_i), .reset_in_i(reset_in_i),
	.ack_button_i(ack_button_i), .display_code_o(display_code_o), .outputs_o(outputs_o),
	.sync_start_o(sync_start_o), .load_accept_o(load_accept_o), .internal_reset_o(internal_reset_o));
